// [b1srm_top.sv]
// bank 1 special register map: register file, mirroring and event interrupt
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "b1srm_params.svh"
module b1srm_top (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        EXT_RESET_IN,
  input  wire logic        WDT_RESET_IN,
  input  wire logic        BROWN_OUT_CAUSE_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  input  wire logic [7:0]  INDIRECT_RDATA_IN,
  output logic             INDIRECT_WR_OUT,
  output logic      [7:0]  INDIRECT_WDATA_OUT,
  output logic      [7:0]  INDIRECT_POINTER_OUT,
  input  wire logic        PC_ADVANCE_IN,
  input  wire logic        PC_JUMP_IN,
  input  wire logic [10:0] PC_JUMP_TARGET_IN,
  output logic      [12:0] PC_OUT,
  output logic      [4:0]  PROGRAM_COUNTER_HIGH_LATCH_OUT,
  input  wire logic        INPUT_BUFFER_FULL_IN,
  input  wire logic        OUTPUT_BUFFER_FULL_IN,
  input  wire logic        INPUT_OVERFLOW_IN,
  input  wire logic [5:0]  SERIAL_STATUS_IN,
  output logic      [7:0]  TIMER_OPTION_CONFIG_OUT,
  output logic      [7:0]  PROCESSOR_STATUS_OUT,
  output logic      [5:0]  PORT_A_DIRECTION_OUT,
  output logic      [7:0]  PORT_B_DIRECTION_OUT,
  output logic      [7:0]  PORT_C_DIRECTION_OUT,
  output logic      [7:0]  PORT_D_DIRECTION_OUT,
  output logic      [2:0]  PORT_E_DIRECTION_OUT,
  output logic             PARALLEL_SLAVE_SELECT_OUT,
  output logic      [7:0]  INTERRUPT_CONTROL_OUT,
  output logic      [7:0]  PERIPHERAL_INTERRUPT_ENABLE_OUT,
  output logic      [7:0]  TIMER2_PERIOD_OUT,
  output logic      [7:0]  SERIAL_SLAVE_ADDRESS_OUT,
  output logic             IRQ_OUT
);

  // ***************************************************************
  // request bundle and reset causes
  // ***************************************************************
  b1srm_pkg::b1srm_bus_req_t     req;
  b1srm_pkg::b1srm_psp_t         psp;
  b1srm_pkg::b1srm_reset_cause_t cause;

  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
  assign psp = '{in_full:  INPUT_BUFFER_FULL_IN,
                 out_full: OUTPUT_BUFFER_FULL_IN,
                 overflow: INPUT_OVERFLOW_IN};

  // watchdog outranks the pin when both arrive together
  assign cause = WDT_RESET_IN ? b1srm_pkg::B1SRM_RST_WDOG :
                 EXT_RESET_IN ? b1srm_pkg::B1SRM_RST_PIN : b1srm_pkg::B1SRM_RST_NONE;

  wire other_reset = (cause != b1srm_pkg::B1SRM_RST_NONE);
  wire wdog_reset  = (cause == b1srm_pkg::B1SRM_RST_WDOG);

  // ***************************************************************
  // address decode
  // ***************************************************************
  wire [6:0] low_addr = req.addr[6:0];
  wire       is_core  = (low_addr == 7'h00) ||
                        (low_addr == 7'h02) || (low_addr == 7'h03) ||
                        (low_addr == 7'h04) || (low_addr == 7'h0A) ||
                        (low_addr == 7'h0B);
  // core registers fold onto one decode, so either bank hits the same storage
  wire [7:0] eff_addr = is_core ? {1'b1, low_addr} : req.addr;

  wire hit_ind   = (eff_addr == `B1SRM_ADDR_INDIRECT);
  wire hit_opt   = (eff_addr == `B1SRM_ADDR_OPTION);
  wire hit_pcl   = (eff_addr == `B1SRM_ADDR_PC_LOW);
  wire hit_st    = (eff_addr == `B1SRM_ADDR_STATUS);
  wire hit_ptr   = (eff_addr == `B1SRM_ADDR_POINTER);
  wire hit_da    = (eff_addr == `B1SRM_ADDR_DIR_A);
  wire hit_db    = (eff_addr == `B1SRM_ADDR_DIR_B);
  wire hit_dc    = (eff_addr == `B1SRM_ADDR_DIR_C);
  wire hit_dd    = (eff_addr == `B1SRM_ADDR_DIR_D);
  wire hit_de    = (eff_addr == `B1SRM_ADDR_DIR_E);
  wire hit_lat   = (eff_addr == `B1SRM_ADDR_PC_LATCH);
  wire hit_ic    = (eff_addr == `B1SRM_ADDR_INT_CTRL);
  wire hit_pe    = (eff_addr == `B1SRM_ADDR_PERIPH_EN);
  wire hit_pw    = (eff_addr == `B1SRM_ADDR_POWER);
  wire hit_t2    = (eff_addr == `B1SRM_ADDR_T2_PERIOD);
  wire hit_sa    = (eff_addr == `B1SRM_ADDR_SER_ADDR);
  wire hit_ss    = (eff_addr == `B1SRM_ADDR_SER_STAT);
  wire hit_evs   = (eff_addr == `B1SRM_ADDR_EVT_STATUS);
  wire hit_evm   = (eff_addr == `B1SRM_ADDR_EVT_MASK);

  // a write in a cycle of another reset is dropped, so kept registers stay unchanged
  wire wr_live = req.wr && !other_reset;
  wire wr_ind = wr_live && hit_ind;
  wire wr_opt = wr_live && hit_opt;
  wire wr_pcl = wr_live && hit_pcl;
  wire wr_st  = wr_live && hit_st;
  wire wr_ptr = wr_live && hit_ptr;
  wire wr_lat = wr_live && hit_lat;
  wire wr_de  = wr_live && hit_de;
  wire wr_ic  = wr_live && hit_ic;
  wire wr_pe  = wr_live && hit_pe;
  wire wr_pw  = wr_live && hit_pw;
  wire wr_evm = wr_live && hit_evm;
  wire rd_evs = req.rd && hit_evs;

  // ***************************************************************
  // core registers
  // ***************************************************************
  logic [7:0] status_q;
  logic [7:0] pointer_q;
  logic [7:0] int_ctrl_q;
  logic [7:0] next_status;

  // timeout and power-down bits are hardware owned and never written by software
  assign next_status = wr_st ? ((req.wdata & `B1SRM_ST_WR_MASK) |
                                (status_q & ~`B1SRM_ST_WR_MASK)) : status_q;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      status_q <= `B1SRM_RST_STATUS;
    end else if (other_reset) begin
      // bank selects cleared, arithmetic flags kept, timeout bit tells the cause
      status_q <= (status_q & `B1SRM_ST_KEEP_OTHER) |
                  {3'h0, ~wdog_reset & status_q[`B1SRM_ST_TIMEOUT],
                   status_q[`B1SRM_ST_POWERDOWN] | wdog_reset, 3'h0};
    end else begin
      status_q <= next_status;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pointer_q <= `B1SRM_RST_POINTER;
    end else if (wr_ptr) begin
      pointer_q <= req.wdata;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      int_ctrl_q <= `B1SRM_RST_INT_CTRL;
    end else if (other_reset) begin
      int_ctrl_q <= int_ctrl_q & `B1SRM_IC_KEEP_OTHER;
    end else if (wr_ic) begin
      int_ctrl_q <= req.wdata;
    end
  end

  // indirect access port has no storage: it forwards to data memory at the pointer
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      INDIRECT_WR_OUT    <= 1'b0;
      INDIRECT_WDATA_OUT <= 8'h00;
    end else begin
      INDIRECT_WR_OUT    <= wr_ind;
      INDIRECT_WDATA_OUT <= wr_ind ? req.wdata : INDIRECT_WDATA_OUT;
    end
  end

  b1srm_pc_unit u_pc (
    .clk_in         (CORE_CLK_IN),
    .rst_n_in       (RST_N_IN),
    .soft_clear_in  (other_reset),
    .advance_in     (PC_ADVANCE_IN),
    .jump_in        (PC_JUMP_IN),
    .jump_target_in (PC_JUMP_TARGET_IN),
    .low_wr_in      (wr_pcl),
    .latch_wr_in    (wr_lat),
    .wdata_in       (req.wdata),
    .pc_out         (PC_OUT),
    .latch_out      (PROGRAM_COUNTER_HIGH_LATCH_OUT)
  );

  // ***************************************************************
  // plain configuration registers
  // ***************************************************************
  logic [7:0] option_q;
  logic [5:0] dir_a_q;
  logic [7:0] dir_b_q;
  logic [7:0] dir_c_q;
  logic [7:0] dir_d_q;
  logic [7:0] periph_en_q;
  logic [7:0] t2_period_q;
  logic [7:0] ser_addr_q;
  logic [5:0] ser_stat_q;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      option_q    <= `B1SRM_RST_OPTION;
      dir_a_q     <= `B1SRM_RST_DIR_A;
      dir_b_q     <= `B1SRM_RST_DIR_8;
      dir_c_q     <= `B1SRM_RST_DIR_8;
      dir_d_q     <= `B1SRM_RST_DIR_8;
      periph_en_q <= `B1SRM_RST_PERIPH_EN;
      t2_period_q <= `B1SRM_RST_T2_PERIOD;
      ser_addr_q  <= `B1SRM_RST_SER_ADDR;
    end else if (other_reset) begin
      // these carry the same value for every kind of reset
      option_q    <= `B1SRM_RST_OPTION;
      dir_a_q     <= `B1SRM_RST_DIR_A;
      dir_b_q     <= `B1SRM_RST_DIR_8;
      dir_c_q     <= `B1SRM_RST_DIR_8;
      dir_d_q     <= `B1SRM_RST_DIR_8;
      periph_en_q <= `B1SRM_RST_PERIPH_EN;
      t2_period_q <= `B1SRM_RST_T2_PERIOD;
      ser_addr_q  <= `B1SRM_RST_SER_ADDR;
    end else if (req.wr) begin
      option_q    <= wr_opt ? req.wdata : option_q;
      dir_a_q     <= hit_da ? req.wdata[5:0] : dir_a_q;
      dir_b_q     <= hit_db ? req.wdata : dir_b_q;
      dir_c_q     <= hit_dc ? req.wdata : dir_c_q;
      dir_d_q     <= hit_dd ? req.wdata : dir_d_q;
      // bit 6 is stored as written; software is expected to leave it clear
      periph_en_q <= wr_pe ? (req.wdata & `B1SRM_PE_IMPL_MASK) : periph_en_q;
      t2_period_q <= hit_t2 ? req.wdata : t2_period_q;
      ser_addr_q  <= hit_sa ? req.wdata : ser_addr_q;
    end
  end

  // serial status is read-only and simply follows the port
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ser_stat_q <= `B1SRM_RST_SER_STAT;
    end else begin
      ser_stat_q <= other_reset ? `B1SRM_RST_SER_STAT : SERIAL_STATUS_IN;
    end
  end

  // ***************************************************************
  // port E control and parallel slave flags
  // ***************************************************************
  logic       in_full_q;
  logic       out_full_q;
  logic       overflow_q;
  logic       psp_sel_q;
  logic [2:0] dir_e_q;
  logic [7:0] dir_e_read;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      in_full_q  <= 1'b0;
      out_full_q <= 1'b0;
      overflow_q <= 1'b0;
      psp_sel_q  <= 1'b0;
      dir_e_q    <= `B1SRM_RST_DIR_E;
    end else if (other_reset) begin
      in_full_q  <= 1'b0;
      out_full_q <= 1'b0;
      overflow_q <= 1'b0;
      psp_sel_q  <= 1'b0;
      dir_e_q    <= `B1SRM_RST_DIR_E;
    end else begin
      in_full_q  <= psp.in_full;
      out_full_q <= psp.out_full;
      // a new overflow beats a software clear in the same cycle
      overflow_q <= psp.overflow | (wr_de ? req.wdata[`B1SRM_DE_IOV] : overflow_q);
      psp_sel_q  <= wr_de ? req.wdata[`B1SRM_DE_PSP] : psp_sel_q;
      dir_e_q    <= wr_de ? req.wdata[2:0] : dir_e_q;
    end
  end

  // bit 3 has no storage and reads zero
  assign dir_e_read = {in_full_q, out_full_q, overflow_q, psp_sel_q, 1'b0, dir_e_q};

  // ***************************************************************
  // power flags, caught just after the power-up reset lets go
  // ***************************************************************
  logic [1:0] power_q;
  logic       power_fresh;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      power_fresh <= 1'b1;
      power_q     <= `B1SRM_RST_POWER;
    end else if (power_fresh) begin
      // brown-out clears only its own flag; power-on leaves the brown-out flag set
      power_fresh <= 1'b0;
      power_q     <= {BROWN_OUT_CAUSE_IN, ~BROWN_OUT_CAUSE_IN};
    end else if (wr_pw) begin
      // other resets leave these alone; software re-arms them with a write
      power_q     <= req.wdata[1:0];
    end
  end

  // ***************************************************************
  // event status, mask and interrupt
  // ***************************************************************
  logic [`B1SRM_EVT_W-1:0] evt_q;
  logic [`B1SRM_EVT_W-1:0] evt_mask_q;
  logic [`B1SRM_EVT_W-1:0] evt_hit;
  logic [`B1SRM_EVT_W-1:0] next_evt;

  assign evt_hit[`B1SRM_EVT_OVERFLOW]  = psp.overflow;
  assign evt_hit[`B1SRM_EVT_IN_FULL]   = psp.in_full & ~in_full_q;
  assign evt_hit[`B1SRM_EVT_OUT_EMPTY] = ~psp.out_full & out_full_q;
  assign evt_hit[`B1SRM_EVT_WATCHDOG]  = wdog_reset;

  genvar gi;
  generate
    for (gi = 0; gi < `B1SRM_EVT_W; gi = gi + 1) begin : g_evt
      // a read clears, but an event in the read cycle stays pending
      assign next_evt[gi] = evt_hit[gi] | (evt_q[gi] & ~rd_evs);
      always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          evt_q[gi] <= 1'b0;
        end else begin
          evt_q[gi] <= next_evt[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      evt_mask_q <= '0;
      IRQ_OUT    <= 1'b0;
    end else begin
      evt_mask_q <= wr_evm ? req.wdata[`B1SRM_EVT_W-1:0] : evt_mask_q;
      IRQ_OUT    <= |(next_evt & (wr_evm ? req.wdata[`B1SRM_EVT_W-1:0] : evt_mask_q));
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  logic [7:0] read_mux;

  always_comb begin
    read_mux = 8'h00;
    if (hit_ind) begin
      read_mux = INDIRECT_RDATA_IN;
    end else if (hit_opt) begin
      read_mux = option_q;
    end else if (hit_pcl) begin
      read_mux = PC_OUT[7:0];
    end else if (hit_st) begin
      read_mux = status_q;
    end else if (hit_ptr) begin
      read_mux = pointer_q;
    end else if (hit_da) begin
      read_mux = {2'h0, dir_a_q};
    end else if (hit_db) begin
      read_mux = dir_b_q;
    end else if (hit_dc) begin
      read_mux = dir_c_q;
    end else if (hit_dd) begin
      read_mux = dir_d_q;
    end else if (hit_de) begin
      read_mux = dir_e_read;
    end else if (hit_lat) begin
      read_mux = {3'h0, PROGRAM_COUNTER_HIGH_LATCH_OUT};
    end else if (hit_ic) begin
      read_mux = int_ctrl_q;
    end else if (hit_pe) begin
      read_mux = periph_en_q;
    end else if (hit_pw) begin
      read_mux = {6'h00, power_q};
    end else if (hit_t2) begin
      read_mux = t2_period_q;
    end else if (hit_sa) begin
      read_mux = ser_addr_q;
    end else if (hit_ss) begin
      read_mux = {2'h0, ser_stat_q};
    end else if (hit_evs) begin
      read_mux = {4'h0, evt_q};
    end else if (hit_evm) begin
      read_mux = {4'h0, evt_mask_q};
    end else begin
      read_mux = 8'h00;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= req.rd ? read_mux : 8'h00;
    end
  end

  // ***************************************************************
  // outputs straight from storage
  // ***************************************************************
  assign INDIRECT_POINTER_OUT            = pointer_q;
  assign TIMER_OPTION_CONFIG_OUT         = option_q;
  assign PROCESSOR_STATUS_OUT            = status_q;
  assign PORT_A_DIRECTION_OUT            = dir_a_q;
  assign PORT_B_DIRECTION_OUT            = dir_b_q;
  assign PORT_C_DIRECTION_OUT            = dir_c_q;
  assign PORT_D_DIRECTION_OUT            = dir_d_q;
  assign PORT_E_DIRECTION_OUT            = dir_e_q;
  assign PARALLEL_SLAVE_SELECT_OUT       = psp_sel_q;
  assign INTERRUPT_CONTROL_OUT           = int_ctrl_q;
  assign PERIPHERAL_INTERRUPT_ENABLE_OUT = periph_en_q;
  assign TIMER2_PERIOD_OUT               = t2_period_q;
  assign SERIAL_SLAVE_ADDRESS_OUT        = ser_addr_q;

endmodule
`default_nettype wire

// [b1srm_params.svh]
// constants of the bank 1 special register map: offsets, fields, reset values
//
// Notes on behaviour
// - core registers answer in both banks alike
// - upper program counter byte never directly accessible
// - five-bit latch feeds program counter bits 12:8 on a low-byte write, bits 12:11 on a jump
// - power-up values also on pin/watchdog reset, except pointer, power, event and some status/interrupt control bits
// - port E control holds flags, gap, three directions
`ifndef B1SRM_PARAMS_SVH
`define B1SRM_PARAMS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define B1SRM_ADDR_INDIRECT     8'h80
`define B1SRM_ADDR_OPTION       8'h81
`define B1SRM_ADDR_PC_LOW       8'h82
`define B1SRM_ADDR_STATUS       8'h83
`define B1SRM_ADDR_POINTER      8'h84
`define B1SRM_ADDR_DIR_A        8'h85
`define B1SRM_ADDR_DIR_B        8'h86
`define B1SRM_ADDR_DIR_C        8'h87
`define B1SRM_ADDR_DIR_D        8'h88
`define B1SRM_ADDR_DIR_E        8'h89
`define B1SRM_ADDR_PC_LATCH     8'h8A
`define B1SRM_ADDR_INT_CTRL     8'h8B
`define B1SRM_ADDR_PERIPH_EN    8'h8C
`define B1SRM_ADDR_POWER        8'h8E
`define B1SRM_ADDR_T2_PERIOD    8'h92
`define B1SRM_ADDR_SER_ADDR     8'h93
`define B1SRM_ADDR_SER_STAT     8'h94
`define B1SRM_ADDR_EVT_STATUS   8'hA0
`define B1SRM_ADDR_EVT_MASK     8'hA1
`define B1SRM_BANK_SELECT_BIT   7

// ***************************************************************
// field positions and masks
// ***************************************************************
`define B1SRM_ST_TIMEOUT        4
`define B1SRM_ST_POWERDOWN      3
`define B1SRM_ST_WR_MASK        8'hE7
`define B1SRM_ST_KEEP_OTHER     8'h07
`define B1SRM_DE_IBF            7
`define B1SRM_DE_OBF            6
`define B1SRM_DE_IOV            5
`define B1SRM_DE_PSP            4
`define B1SRM_PE_IMPL_MASK      8'hCF
`define B1SRM_IC_KEEP_OTHER     8'h01
`define B1SRM_EVT_W             4
`define B1SRM_EVT_OVERFLOW      0
`define B1SRM_EVT_IN_FULL       1
`define B1SRM_EVT_OUT_EMPTY     2
`define B1SRM_EVT_WATCHDOG      3

// ***************************************************************
// reset values
// ***************************************************************
`define B1SRM_RST_OPTION        8'hFF
`define B1SRM_RST_STATUS        8'h18
`define B1SRM_RST_POINTER       8'h00
`define B1SRM_RST_DIR_A         6'h3F
`define B1SRM_RST_DIR_8         8'hFF
`define B1SRM_RST_DIR_E         3'h7
`define B1SRM_RST_INT_CTRL      8'h00
`define B1SRM_RST_PERIPH_EN     8'h00
`define B1SRM_RST_POWER         2'h0
`define B1SRM_RST_T2_PERIOD     8'hFF
`define B1SRM_RST_SER_ADDR      8'h00
`define B1SRM_RST_SER_STAT      6'h00
`define B1SRM_RST_PC            13'h0000
`define B1SRM_RST_PC_LATCH      5'h00

`endif

// [b1srm_pkg.sv]
// types shared by the bank 1 special register map
package b1srm_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } b1srm_bus_req_t;

  typedef struct packed {
    logic in_full;
    logic out_full;
    logic overflow;
  } b1srm_psp_t;

  typedef enum logic [2:0] {
    B1SRM_RST_NONE = 3'b001,
    B1SRM_RST_PIN  = 3'b010,
    B1SRM_RST_WDOG = 3'b100
  } b1srm_reset_cause_t;

endpackage

// [b1srm_pc_unit.sv]
// program counter with its five-bit high latch
`timescale 1ns/1ps
`default_nettype none
`include "b1srm_params.svh"
module b1srm_pc_unit (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        soft_clear_in,
  input  wire logic        advance_in,
  input  wire logic        jump_in,
  input  wire logic [10:0] jump_target_in,
  input  wire logic        low_wr_in,
  input  wire logic        latch_wr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [12:0] pc_out,
  output logic      [4:0]  latch_out
);

  logic [12:0] next_pc;

  // the upper byte has no write path of its own: a low-byte write loads it from the latch, a jump takes bits 12:11 from it
  assign next_pc = low_wr_in ? {latch_out, wdata_in} :
                   jump_in   ? {latch_out[4:3], jump_target_in} :
                   advance_in ? pc_out + 13'h0001 : pc_out;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out <= `B1SRM_RST_PC;
    end else if (soft_clear_in) begin
      pc_out <= `B1SRM_RST_PC;
    end else begin
      pc_out <= next_pc;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_out <= `B1SRM_RST_PC_LATCH;
    end else if (soft_clear_in) begin
      latch_out <= `B1SRM_RST_PC_LATCH;
    end else if (latch_wr_in) begin
      latch_out <= wdata_in[4:0];
    end
  end

endmodule
`default_nettype wire

// [b1srm_unused_guard.sv]
// holds no logic: every module of the block lives in the other design files

// [b1srm_top_monitor.sv]
// concurrent checks on the ports of the bank 1 register map
`timescale 1ns/1ps
`default_nettype none
module b1srm_top_monitor (
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        EXT_RESET_IN,
  input wire logic        WDT_RESET_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [7:0]  WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic [7:0]  INDIRECT_RDATA_IN,
  input wire logic        INDIRECT_WR_OUT,
  input wire logic [7:0]  INDIRECT_WDATA_OUT,
  input wire logic [7:0]  INDIRECT_POINTER_OUT,
  input wire logic [12:0] PC_OUT,
  input wire logic [4:0]  PROGRAM_COUNTER_HIGH_LATCH_OUT,
  input wire logic [7:0]  PORT_B_DIRECTION_OUT,
  input wire logic [2:0]  PORT_E_DIRECTION_OUT,
  input wire logic        PARALLEL_SLAVE_SELECT_OUT
);
  // ****************************************************
  // checks
  // ****************************************************
  // writes during another reset are dropped, so only clean writes are judged
  wire wr_ok = WR_IN && !EXT_RESET_IN && !WDT_RESET_IN;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_pc_cleared;
    PC_OUT == 13'h0000 && PROGRAM_COUNTER_HIGH_LATCH_OUT == 5'h00;
  endsequence
  sequence s_dir_reloaded;
    PORT_B_DIRECTION_OUT == 8'hFF && PORT_E_DIRECTION_OUT == 3'h7;
  endsequence
  a_other_rst_vals: assert property (EXT_RESET_IN |=> s_pc_cleared ##0 s_dir_reloaded)
    else $error("other reset values wrong");
  a_unmapped_zero: assert property (RD_IN &&
    ADDR_IN inside {8'h8D, [8'h8F:8'h91], [8'h95:8'h9F]} |=> RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_indirect_rd: assert property (RD_IN && ADDR_IN[6:0] == 7'h00
    |=> RDATA_OUT == $past(INDIRECT_RDATA_IN)) else $error("indirect read wrong");
  a_indirect_wr: assert property (wr_ok && ADDR_IN[6:0] == 7'h00
    |=> INDIRECT_WR_OUT && INDIRECT_WDATA_OUT == $past(WDATA_IN)) else $error("indirect write");
  a_pointer_mirror: assert property (wr_ok && ADDR_IN[6:0] == 7'h04
    |=> INDIRECT_POINTER_OUT == $past(WDATA_IN)) else $error("pointer write wrong");
  a_latch_mirror: assert property (wr_ok && ADDR_IN[6:0] == 7'h0A
    |=> PROGRAM_COUNTER_HIGH_LATCH_OUT == $past(WDATA_IN[4:0])) else $error("latch write");
  a_pc_transfer: assert property (wr_ok && ADDR_IN[6:0] == 7'h02 |=>
    PC_OUT == {$past(PROGRAM_COUNTER_HIGH_LATCH_OUT), $past(WDATA_IN)}) else $error("pc load");
  a_port_e_ctrl: assert property (wr_ok && ADDR_IN == 8'h89 |=>
    {PARALLEL_SLAVE_SELECT_OUT, PORT_E_DIRECTION_OUT} == {$past(WDATA_IN[4]), $past(WDATA_IN[2:0])})
    else $error("port E control write wrong");
endmodule
bind b1srm_top b1srm_top_monitor b1srm_top_monitor_i (.*);
`default_nettype wire

// [b1srm_top_tb.sv]
// self-checking bench of the bank 1 register map
`timescale 1ns/1ps
`default_nettype none
module b1srm_top_tb;
  logic        CORE_CLK_IN, RST_N_IN, EXT_RESET_IN, WDT_RESET_IN, BROWN_OUT_CAUSE_IN, WR_IN;
  logic        RD_IN, PC_ADVANCE_IN, PC_JUMP_IN, INPUT_BUFFER_FULL_IN, OUTPUT_BUFFER_FULL_IN;
  logic        INPUT_OVERFLOW_IN, INDIRECT_WR_OUT, PARALLEL_SLAVE_SELECT_OUT, IRQ_OUT;
  logic [7:0]  ADDR_IN, WDATA_IN, RDATA_OUT, INDIRECT_RDATA_IN, INDIRECT_WDATA_OUT;
  logic [7:0]  INDIRECT_POINTER_OUT, TIMER_OPTION_CONFIG_OUT, PROCESSOR_STATUS_OUT;
  logic [7:0]  PORT_B_DIRECTION_OUT, PORT_C_DIRECTION_OUT, PORT_D_DIRECTION_OUT;
  logic [7:0]  INTERRUPT_CONTROL_OUT, PERIPHERAL_INTERRUPT_ENABLE_OUT, TIMER2_PERIOD_OUT;
  logic [7:0]  SERIAL_SLAVE_ADDRESS_OUT, d, p;
  logic [10:0] PC_JUMP_TARGET_IN;
  logic [12:0] PC_OUT;
  logic [5:0]  SERIAL_STATUS_IN, PORT_A_DIRECTION_OUT;
  logic [4:0]  PROGRAM_COUNTER_HIGH_LATCH_OUT;
  logic [2:0]  PORT_E_DIRECTION_OUT;
  logic        b;
  int          num_errors = 0;
  int          tests_run = 0;
  b1srm_top b1srm_top_i (.*);
  initial begin
    CORE_CLK_IN = 0;
    forever #2.5 CORE_CLK_IN = ~CORE_CLK_IN;
  end
  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [7:0] por_val(input logic [7:0] a);
    case (a)
      8'h81, 8'h86, 8'h87, 8'h88, 8'h92: return 8'hFF;
      8'h85: return 8'h3F;
      8'h89: return 8'h07;
      8'h83: return 8'h18;
      8'h8E: return 8'h02; // brown-out cause was held high at release
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CORE_CLK_IN) {ADDR_IN, WDATA_IN, WR_IN} <= {a, v, 1'b1};
    @(posedge CORE_CLK_IN) WR_IN <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CORE_CLK_IN) {ADDR_IN, RD_IN} <= {a, 1'b1};
    @(posedge CORE_CLK_IN) RD_IN <= 1'b0;
    #1 chk({5'h00, RDATA_OUT}, {5'h00, e});
  endtask
  task automatic pulse_rst(input logic wdog);
    @(posedge CORE_CLK_IN) {WDT_RESET_IN, EXT_RESET_IN} <= {wdog, !wdog};
    @(posedge CORE_CLK_IN) {WDT_RESET_IN, EXT_RESET_IN} <= 2'b00;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // the only wait bound: a hang counts as a mismatch
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  // ****************************************************
  // scenarios
  // ****************************************************
  initial begin
    {RST_N_IN, EXT_RESET_IN, WDT_RESET_IN, WR_IN, RD_IN, PC_ADVANCE_IN, PC_JUMP_IN} = 7'h00;
    {INPUT_BUFFER_FULL_IN, OUTPUT_BUFFER_FULL_IN, INPUT_OVERFLOW_IN, BROWN_OUT_CAUSE_IN} = 4'h1;
    {ADDR_IN, WDATA_IN, INDIRECT_RDATA_IN, PC_JUMP_TARGET_IN, SERIAL_STATUS_IN} = 41'h0;
    void'($urandom(32'hAFA55C94));
    repeat (3) @(posedge CORE_CLK_IN);
    RST_N_IN <= 1'b1;
    for (int a = 8'h80; a <= 8'h9F; a++) rd(8'(a), por_val(8'(a)));
    chk({12'h000, {TIMER_OPTION_CONFIG_OUT, PORT_A_DIRECTION_OUT, PORT_C_DIRECTION_OUT,
                   PORT_D_DIRECTION_OUT, TIMER2_PERIOD_OUT, INTERRUPT_CONTROL_OUT,
                   SERIAL_SLAVE_ADDRESS_OUT} === {8'hFF, 6'h3F, 16'hFFFF, 8'hFF, 16'h0000}},
        13'h0001);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      p = 8'($urandom);
      b = 1'($urandom);
      @(posedge CORE_CLK_IN) INDIRECT_RDATA_IN <= p;
      rd({b, 7'h00}, p);
      wr({b, 7'h04}, d);
      rd({!b, 7'h04}, d);
      wr({b, 7'h0A}, d);
      rd({!b, 7'h0A}, {3'h0, d[4:0]});
      wr({!b, 7'h02}, p);
      chk(PC_OUT, {d[4:0], p});
      wr({b, 7'h00}, p);
      wr(8'h8D, d);
      rd(8'h8D, 8'h00);
    end
    $display("test mirror and pc done");
    wr(8'h89, 8'h1D);
    rd(8'h89, 8'h15);
    wr(8'h86, 8'h5A);
    pulse_rst(1'b0);
    rd(8'h86, 8'hFF);
    rd(8'h84, d);
    rd(8'h89, 8'h07);
    pulse_rst(1'b1);
    rd(8'h83, 8'h08);
    rd(8'h8E, 8'h02);
    rd(8'hA0, 8'h08);
    rd(8'hA0, 8'h00);
    $display("test other resets done");
    wr(8'h83, 8'h07);
    rd(8'h83, 8'h0F);
    wr(8'h8E, 8'h03);
    rd(8'h8E, 8'h03);
    wr(8'h8C, 8'hBF);
    chk({5'h00, PROCESSOR_STATUS_OUT}, 13'h000F);
    chk({5'h00, PERIPHERAL_INTERRUPT_ENABLE_OUT}, 13'h008F);
    $display("test software kept bits done");
    wr(8'hA1, 8'h01);
    @(posedge CORE_CLK_IN) INPUT_BUFFER_FULL_IN <= 1'b1;
    repeat (3) @(posedge CORE_CLK_IN);
    #1 chk({12'h000, IRQ_OUT}, 13'h0000);
    @(posedge CORE_CLK_IN) INPUT_OVERFLOW_IN <= 1'b1;
    @(posedge CORE_CLK_IN) INPUT_OVERFLOW_IN <= 1'b0;
    #1 chk({12'h000, IRQ_OUT}, 13'h0001);
    rd(8'hA0, 8'h03);
    chk({12'h000, IRQ_OUT}, 13'h0000);
    $display("test interrupt done");
    stop_test();
  end
endmodule
`default_nettype wire
